/* File: hw/sads_top.sv */
// converter sequencer: ahb-lite registers, clock select, adc/dac cycle control
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "sads_params.svh"

module sads_top
  import sads_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rc_osc_tick,
  input  wire logic [2:0]  timer_ovf,
  input  wire logic        isr_ack,
  input  wire logic        cmp_out,
  output logic             conversion_done_flag,
  output logic             start_busy,
  output logic             ana_power,
  output logic             ana_dac_mode,
  output logic             ana_connect,
  output logic             ana_select_a,
  output logic      [2:0]  ana_channel,
  output logic      [1:0]  ana_src,
  output logic             ana_int_ref,
  output logic             ana_sample,
  output logic      [9:0]  sar_code,
  output logic             dac_drive,
  output logic             pin_force_input,
  output logic             rc_osc_enable
);

  sads_state_t st_r;
  sads_state_t st_nxt;

  logic        addr_ok;
  logic [1:0]  addr_reg;
  logic        conv_tick;
  logic [6:0]  div_mask;
  logic        start_req;
  logic        conv_end;
  logic [3:0]  first_cyc;
  logic [3:0]  last_cyc;
  logic [3:0]  bit_off;
  logic [3:0]  bit_idx;
  logic [9:0]  code_v;

  // ----------------------------------------------------------------
  // address decode and converter clock
  // ----------------------------------------------------------------
  assign addr_ok  = (haddr[31:10] == 22'h0) && (haddr[9:4] == `SADS_IDX_CTRL >> 2);
  assign addr_reg = haddr[3:2];
  // code n>0 ticks every 2^n system clocks, independent of cpu dividers
  assign div_mask = 7'h7f >> (3'h7 - st_r.ck);
  assign conv_tick = (st_r.ck == 3'h0) ?
                     (rc_osc_tick && (st_r.rc == `SADS_RC_DIV_LAST)) :
                     ((st_r.div & div_mask) == div_mask);
  assign first_cyc = st_r.dac ? `SADS_DAC_FIRST : `SADS_ADC_FIRST;
  assign last_cyc  = st_r.dac ? `SADS_DAC_LAST : `SADS_ADC_LAST;
  assign conv_end  = (st_r.phase == SADS_RUN) && conv_tick && (st_r.cyc == last_cyc);
  assign bit_off   = st_r.cyc - first_cyc;
  assign bit_idx   = `SADS_BITS_M1 - bit_off;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    start_req = 1'b0;
    code_v    = st_r.code;
    st_nxt.div = st_r.div + 7'h1;
    if (rc_osc_tick) begin
      st_nxt.rc = st_r.rc + 2'h1;
    end

    // bus address phase
    st_nxt.a_wr  = hsel && hready && htrans[1] && hwrite && addr_ok;
    st_nxt.a_reg = addr_reg;
    if (hsel && hready && htrans[1] && !hwrite) begin
      st_nxt.hrdata = 32'h0;
      if (addr_ok) begin
        case (addr_reg)
          2'h0: st_nxt.hrdata[7:0] = {st_r.done, st_r.phase == SADS_RUN, st_r.dac,
                                      st_r.en, st_r.ladj, st_r.ck};
          2'h1: st_nxt.hrdata[7:0] = {st_r.connect, st_r.isrc, st_r.trigger_select, st_r.select_a,
                                      st_r.ch};
          // result pair readable only in adc mode; data is write-only in dac mode
          2'h2: st_nxt.hrdata[7:0] = st_r.dac ? 8'h00 :
                                     (st_r.ladj ? {st_r.res[1:0], 6'h00} : st_r.res[7:0]);
          2'h3: st_nxt.hrdata[7:0] = st_r.dac ? 8'h00 :
                                     (st_r.ladj ? st_r.res[9:2] :
                                      {{6{st_r.res[9]}}, st_r.res[9:8]});
          default: st_nxt.hrdata = 32'h0;
        endcase
      end
    end

    // bus data phase write
    if (st_r.a_wr) begin
      case (st_r.a_reg)
        2'h0: begin
          st_nxt.dac  = hwdata[`SADS_C_DAC];
          st_nxt.en   = hwdata[`SADS_C_EN];
          st_nxt.ladj = hwdata[`SADS_C_LADJ];
          st_nxt.ck   = hwdata[`SADS_C_CK_HI:`SADS_C_CK_LO];
          if (!hwdata[`SADS_C_DONE]) begin
            st_nxt.done = 1'b0;
          end
          start_req = hwdata[`SADS_C_START] && hwdata[`SADS_C_EN];
        end
        2'h1: begin
          st_nxt.connect = hwdata[`SADS_I_CONNECT];
          st_nxt.isrc    = hwdata[`SADS_I_ISRC];
          st_nxt.trigger_select     = hwdata[`SADS_I_TRG_HI:`SADS_I_TRG_LO];
          st_nxt.select_a    = hwdata[`SADS_I_SELECT_A];
          st_nxt.ch      = hwdata[`SADS_I_CH_HI:`SADS_I_CH_LO];
        end
        2'h2: begin
          if (st_r.dac) begin
            st_nxt.dlo = hwdata[7:0];
          end
        end
        2'h3: begin
          if (st_r.dac) begin
            st_nxt.dhi = hwdata[7:0];
          end
        end
        default: st_nxt.dlo = st_r.dlo;
      endcase
    end

    // timer trigger, code 0 is software only
    if (st_r.en && (st_r.trigger_select != 2'h0) && timer_ovf[st_r.trigger_select - 2'h1]) begin
      start_req = 1'b1;
    end

    // done flag: vectoring clears it; a pending set wins over that clear
    if (isr_ack) begin
      st_nxt.done = 1'b0;
    end

    case (st_r.phase)
      SADS_IDLE: begin
        if (start_req) begin
          st_nxt.phase = SADS_RUN;
          st_nxt.cyc   = 4'h0;
          st_nxt.code  = 10'h0;
          // one system clock to copy the data pair, before converter cycle two
          st_nxt.dbuf  = (st_r.ladj ? {st_r.dhi, st_r.dlo[7:6]} :
                          {st_r.dhi[1:0], st_r.dlo}) ^ `SADS_MID_CODE;
        end
      end
      SADS_RUN: begin
        // requests while running are dropped, never restart the sequence
        if (conv_tick) begin
          st_nxt.cyc = st_r.cyc + 4'h1;
          if (st_r.cyc == first_cyc - 4'h1) begin
            code_v = `SADS_MID_CODE;
          end
          if ((st_r.cyc >= first_cyc) && (bit_off <= `SADS_BITS_M1)) begin
            code_v[bit_idx] = st_r.dac ? st_r.dbuf[bit_idx] : cmp_out;
            if (bit_idx != 4'h0) begin
              code_v[bit_idx - 4'h1] = 1'b1;
            end
          end
          st_nxt.code = code_v;
          if (st_r.dac && (st_r.cyc == `SADS_DAC_PROP - 4'h1)) begin
            st_nxt.dac_drive = 1'b1;
          end
          if (conv_end) begin
            st_nxt.phase = SADS_SYNC;
            if (!st_r.dac) begin
              st_nxt.res = code_v ^ `SADS_MID_CODE;
            end
          end
        end
      end
      SADS_SYNC: begin
        st_nxt.phase = SADS_IDLE;
        st_nxt.done  = 1'b1;
      end
      default: st_nxt.phase = SADS_IDLE;
    endcase

    // disabling drops any conversion and the dac drive
    if (!st_nxt.en) begin
      st_nxt.phase = SADS_IDLE;
    end
    if (!(st_nxt.en && st_nxt.dac)) begin
      st_nxt.dac_drive = 1'b0;
    end

    // bus response and analog controls
    st_nxt.hreadyout   = 1'b1;
    st_nxt.hresp       = 1'b0;
    st_nxt.power       = st_nxt.en;
    st_nxt.rc_osc_en   = st_nxt.en && (st_nxt.ck == 3'h0);
    st_nxt.force_in    = st_nxt.en && st_nxt.dac;
    st_nxt.ana_connect = st_nxt.en && !st_nxt.dac && st_nxt.connect;
    st_nxt.ana_select_a    = st_nxt.en && !st_nxt.dac && st_nxt.select_a;
    st_nxt.ana_ref     = !st_nxt.dac && (st_nxt.ch == `SADS_CH_INTERNAL);
    st_nxt.ana_src     = (st_nxt.dac || (st_nxt.ch != `SADS_CH_INTERNAL)) ? 2'h0 :
                         (st_nxt.isrc ? 2'h2 : 2'h1);
    st_nxt.sample      = (st_nxt.phase == SADS_RUN) && !st_nxt.dac &&
                         (st_nxt.cyc == `SADS_ADC_SAMPLE);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata               = st_r.hrdata;
  assign hreadyout            = st_r.hreadyout;
  assign hresp                = st_r.hresp;
  assign conversion_done_flag = st_r.done;
  assign start_busy           = (st_r.phase == SADS_RUN);
  assign ana_power            = st_r.power;
  assign ana_dac_mode         = st_r.force_in;
  assign ana_connect          = st_r.ana_connect;
  assign ana_select_a             = st_r.ana_select_a;
  assign ana_channel          = st_r.ch;
  assign ana_src              = st_r.ana_src;
  assign ana_int_ref          = st_r.ana_ref;
  assign ana_sample           = st_r.sample;
  assign sar_code             = st_r.code;
  assign dac_drive            = st_r.dac_drive;
  assign pin_force_input      = st_r.force_in;
  assign rc_osc_enable        = st_r.rc_osc_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  adc_length_a: assert property (conv_end && !st_r.dac |-> st_r.cyc == 4'hc)
    else $error("adc conversion not 13 cycles");
  dac_length_a: assert property (conv_end && st_r.dac |-> st_r.cyc == 4'ha)
    else $error("dac conversion not 11 cycles");
  adc_sample_a: assert property (ana_sample |-> start_busy && st_r.cyc == 4'h2)
    else $error("sample outside third cycle");
  done_sync_a: assert property (conv_end && st_nxt.en |=> ##1 conversion_done_flag)
    else $error("done flag late");
  busy_clear_a: assert property (conv_end |=> !start_busy)
    else $error("busy not cleared at end");
  start_take_a: assert property (
    st_r.phase == SADS_IDLE && start_req && st_nxt.en |=> start_busy && st_r.cyc == 4'h0)
    else $error("start not taken");
  no_restart_a: assert property (
    start_busy && start_req && !conv_end && st_nxt.en |=> st_r.cyc >= $past(st_r.cyc))
    else $error("running conversion restarted");
  isr_clear_a: assert property (isr_ack && st_r.phase != SADS_SYNC |=> !conversion_done_flag)
    else $error("done flag not cleared on vectoring");
  result_hold_a: assert property (!conv_end |=> $stable(st_r.res))
    else $error("result changed without completion");
  dac_pins_a: assert property (st_r.en && st_r.dac |-> pin_force_input && !ana_connect)
    else $error("dac mode pins not forced");
  power_off_a: assert property (!st_r.en |-> !ana_power && !start_busy)
    else $error("converter active while disabled");
  rc_clock_a: assert property (st_r.en && st_r.ck == 3'h0 |-> rc_osc_enable)
    else $error("internal oscillator not enabled");

  // ----------------------------------------------------------------
  // sequencing checks
  // ----------------------------------------------------------------
  // built on the registered copy plus st_nxt.en, conv_tick and start_req, with $past adding history flops
  cyc_step_a: assert property (start_busy && !conv_end && st_nxt.en |=>
    st_r.cyc == $past(st_r.cyc) + {3'h0, $past(conv_tick)})
    else $error("converter cycle index skipped or stalled");
  busy_rise_a: assert property ($rose(start_busy) |->
    st_r.cyc == 4'h0 && sar_code == 10'h0)
    else $error("conversion did not start from cycle zero");
  done_rise_a: assert property ($rose(conversion_done_flag) |->
    $past(st_r.phase) == SADS_SYNC)
    else $error("done flag set outside the sync cycle");
  done_win_a: assert property (st_r.phase == SADS_SYNC |=> conversion_done_flag)
    else $error("done flag lost to a same-cycle clear");
  dac_code_a: assert property (conv_end && st_r.dac |=> sar_code == st_r.dbuf)
    else $error("dac output code differs from buffer");
  dbuf_hold_a: assert property (start_busy |=> $stable(st_r.dbuf))
    else $error("dac buffer changed during conversion");
  dac_early_a: assert property ($rose(dac_drive) |->
    start_busy && st_r.cyc == 4'h6)
    else $error("dac output released outside cycle seven");
  dac_drive_a: assert property (dac_drive |-> pin_force_input && ana_power)
    else $error("dac output driven outside dac mode");
  dac_ignore_a: assert property (ana_dac_mode |->
    !ana_connect && !ana_select_a && ana_src == 2'h0)
    else $error("input settings active in dac mode");
  int_src_a: assert property (ana_src != 2'h0 |->
    ana_int_ref && ana_channel == `SADS_CH_INTERNAL)
    else $error("internal source without internal reference");
  clk_src_a: assert property (st_r.ck != 3'h0 |-> !rc_osc_enable)
    else $error("internal oscillator kept on for prescaler clock");
  abort_a: assert property (start_busy && !st_nxt.en |=> st_r.phase == SADS_IDLE)
    else $error("conversion kept running after disable");
  start_off_a: assert property (start_req && !st_nxt.en |=> !start_busy)
    else $error("conversion started while disabled");

  adc_done_c: cover property (conv_end && !st_r.dac);
  dac_done_c: cover property (conv_end && st_r.dac);
  timer_start_c: cover property (st_r.trigger_select != 2'h0 && start_req && !start_busy);
  busy_ignore_c: cover property (start_busy && start_req);
  int_temp_c: cover property (ana_src == 2'h2 && ana_connect);

endmodule

/* File: common/sads_params.svh */
// offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef SADS_PARAMS_SVH
`define SADS_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------------------------------
`define SADS_IDX_CTRL     8'ha4
`define SADS_IDX_INPUT    8'ha5
`define SADS_IDX_RES_LO   8'ha6
`define SADS_IDX_RES_HI   8'ha7
`define SADS_RESET_BYTE   8'h00

// ----------------------------------------------------------------
// converter_control_reg fields
// ----------------------------------------------------------------
`define SADS_C_DONE       7
`define SADS_C_START      6
`define SADS_C_DAC        5
`define SADS_C_EN         4
`define SADS_C_LADJ       3
`define SADS_C_CK_HI      2
`define SADS_C_CK_LO      0

// ----------------------------------------------------------------
// input_control_reg fields
// ----------------------------------------------------------------
`define SADS_I_CONNECT    7
`define SADS_I_ISRC       6
`define SADS_I_TRG_HI     5
`define SADS_I_TRG_LO     4
`define SADS_I_SELECT_A       3
`define SADS_I_CH_HI      2
`define SADS_I_CH_LO      0
`define SADS_CH_INTERNAL  3'h6

// ----------------------------------------------------------------
// sequencing counts in converter clock cycles (index of cycle, from 0), plus bit count, mid code and oscillator divide
// ----------------------------------------------------------------
`define SADS_ADC_LAST     4'hc
`define SADS_DAC_LAST     4'ha
`define SADS_ADC_FIRST    4'h3
`define SADS_DAC_FIRST    4'h1
`define SADS_ADC_SAMPLE   4'h2
`define SADS_DAC_PROP     4'h6
`define SADS_BITS_M1      4'h9
`define SADS_MID_CODE     10'h200
`define SADS_RC_DIV_LAST  2'h3

`endif

/* File: common/sads_pkg.sv */
// types of the converter sequencer
package sads_pkg;

  typedef enum logic [1:0] {
    SADS_IDLE = 2'b00,
    SADS_RUN  = 2'b01,
    SADS_SYNC = 2'b10
  } sads_phase_t;

  typedef struct packed {
    sads_phase_t phase;
    logic [3:0]  cyc;
    logic [9:0]  code;
    logic [9:0]  dbuf;
    logic [9:0]  res;
    logic        done;
    logic        dac;
    logic        en;
    logic        ladj;
    logic [2:0]  ck;
    logic        connect;
    logic        isrc;
    logic [1:0]  trigger_select;
    logic        select_a;
    logic [2:0]  ch;
    logic [7:0]  dlo;
    logic [7:0]  dhi;
    logic [6:0]  div;
    logic [1:0]  rc;
    logic        a_wr;
    logic [1:0]  a_reg;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sample;
    logic        dac_drive;
    logic        force_in;
    logic        ana_connect;
    logic        ana_select_a;
    logic [1:0]  ana_src;
    logic        ana_ref;
    logic        power;
    logic        rc_osc_en;
  } sads_state_t;

endpackage

/* File: tb/sads_top_tb_top.sv */
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
`include "sads_params.svh"

module sads_top_tb_top
  import sads_pkg::*;
;
  // ----------------
  // signals
  // ----------------
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rc_osc_tick = 1'b0;
  logic [2:0]  timer_ovf;
  logic        isr_ack;
  logic        cmp_out;
  logic        conversion_done_flag;
  logic        start_busy;
  logic        ana_power;
  logic        ana_dac_mode;
  logic        ana_connect;
  logic        ana_select_a;
  logic [2:0]  ana_channel;
  logic [1:0]  ana_src;
  logic        ana_int_ref;
  logic        ana_sample;
  logic [9:0]  sar_code;
  logic        dac_drive;
  logic        pin_force_input;
  logic        rc_osc_enable;
  logic [31:0] exp_q[$];
  logic        rd_pend;
  logic [31:0] rnd;
  logic [15:0] e;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc_count = 0;
  int          rc_div = 0;
  int          p;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  sads_top sads_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rc_osc_tick(rc_osc_tick),
    .timer_ovf(timer_ovf), .isr_ack(isr_ack), .cmp_out(cmp_out),
    .conversion_done_flag(conversion_done_flag), .start_busy(start_busy),
    .ana_power(ana_power), .ana_dac_mode(ana_dac_mode), .ana_connect(ana_connect),
    .ana_select_a(ana_select_a), .ana_channel(ana_channel), .ana_src(ana_src),
    .ana_int_ref(ana_int_ref), .ana_sample(ana_sample), .sar_code(sar_code),
    .dac_drive(dac_drive), .pin_force_input(pin_force_input),
    .rc_osc_enable(rc_osc_enable)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // oscillator pulse every third system clock
  always @(posedge hclk) begin
    rc_div <= (rc_div == 2) ? 0 : rc_div + 1;
    rc_osc_tick <= (rc_div == 2);
  end

  // ----------------
  // checking tasks
  // ----------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [15:0] fmt(input logic [9:0] s, input logic ladj);
    return ladj ? {s, 6'h00} : {{6{s[9]}}, s};
  endfunction

  // for reads d is the expected byte
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    rd_pend <= !wr;
    if (!wr) exp_q.push_back({24'h0, d});
    do @(posedge hclk); while (hready !== 1'b1);
    rd_pend <= 1'b0;
  endtask

  always @(posedge hclk) begin
    if (rd_pend === 1'b1 && hready === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, 32'h0);
    end
  end

  // timer pulse mid-run must not restart anything
  task automatic conv(input logic dac);
    int n;
    int smp;
    int drv;
    n = 0;
    smp = 0;
    drv = -1;
    #1;
    chk(start_busy, 1'b1);
    while (start_busy === 1'b1 && n < 4000) begin
      @(posedge hclk);
      timer_ovf <= (n == 10) ? 3'b010 : 3'b000;
      #1;
      n++;
      if (ana_sample === 1'b1) smp++;
      if (dac_drive === 1'b1 && drv < 0) drv = n;
    end
    chk(n >= (dac ? 10 : 12) * p - 2 && n <= (dac ? 11 : 13) * p + 2, 1);
    chk(smp, dac ? 0 : p);
    if (dac) chk(drv >= 5 * p - 2 && drv <= 6 * p + 2, 1);
    chk(conversion_done_flag, 1'b0);
    @(posedge hclk);
    #1;
    chk(conversion_done_flag, 1'b1);
    @(posedge hclk);
  endtask

  always @(posedge hclk) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------
  // stimulus
  // ----------------
  initial begin
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    timer_ovf = 3'h0;
    isr_ack = 1'b0;
    cmp_out = 1'b0;
    rd_pend = 1'b0;
    rnd = 32'h10;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    bus(1'b0, `SADS_IDX_CTRL, `SADS_RESET_BYTE);
    bus(1'b0, `SADS_IDX_INPUT, `SADS_RESET_BYTE);
    bus(1'b1, 8'hb0, 8'h5a);
    bus(1'b0, 8'hb0, 8'h00);
    chk(ana_power, 1'b0);
    $display("test reset values done");
    // every clock code, random comparator level and adjust
    bus(1'b1, `SADS_IDX_INPUT, 8'h82);
    for (int k = 0; k < 8; k++) begin
      rnd = xs(rnd);
      p = (k == 0) ? 12 : (1 << k);
      cmp_out <= rnd[0];
      bus(1'b1, `SADS_IDX_CTRL, {4'h1, rnd[1], 3'(k)});
      bus(1'b0, `SADS_IDX_CTRL, {4'h1, rnd[1], 3'(k)});
      chk(rc_osc_enable, k == 0);
      bus(1'b1, `SADS_IDX_CTRL, {4'h5, rnd[1], 3'(k)});
      conv(1'b0);
      e = fmt(rnd[0] ? 10'h1ff : 10'h200, rnd[1]);
      bus(1'b1, `SADS_IDX_RES_LO, 8'h55);
      bus(1'b0, `SADS_IDX_RES_LO, e[7:0]);
      bus(1'b0, `SADS_IDX_RES_HI, e[15:8]);
      bus(1'b0, `SADS_IDX_CTRL, {4'h9, rnd[1], 3'(k)});
      if (k[0]) begin
        isr_ack <= 1'b1;
        @(posedge hclk);
        isr_ack <= 1'b0;
      end else begin
        bus(1'b1, `SADS_IDX_CTRL, {4'h1, rnd[1], 3'(k)});
      end
      bus(1'b0, `SADS_IDX_CTRL, {4'h1, rnd[1], 3'(k)});
      $display("test adc clock code %0d done", k);
    end
    // connect dropped around a channel change
    bus(1'b1, `SADS_IDX_CTRL, 8'h11);
    bus(1'b1, `SADS_IDX_INPUT, 8'h02);
    bus(1'b1, `SADS_IDX_INPUT, 8'h0e);
    chk(ana_connect, 1'b0);
    bus(1'b1, `SADS_IDX_INPUT, 8'hce);
    bus(1'b0, `SADS_IDX_INPUT, 8'hce);
    chk(ana_channel, 3'h6);
    chk(ana_select_a, 1'b1);
    chk(ana_src, 2'h2);
    chk(ana_int_ref, 1'b1);
    chk(ana_connect & ana_power, 1'b1);
    bus(1'b1, `SADS_IDX_INPUT, 8'h8e);
    bus(1'b0, `SADS_IDX_INPUT, 8'h8e);
    chk(ana_src, 2'h1);
    $display("test input routing done");
    rnd = xs(rnd);
    p = 2;
    e = fmt(rnd[9:0], 1'b0);
    bus(1'b1, `SADS_IDX_CTRL, 8'h31);
    bus(1'b1, `SADS_IDX_RES_LO, e[7:0]);
    bus(1'b1, `SADS_IDX_RES_HI, e[15:8]);
    bus(1'b0, `SADS_IDX_RES_LO, 8'h00);
    chk(pin_force_input & ana_dac_mode, 1'b1);
    chk(ana_connect | ana_select_a | ana_int_ref, 1'b0);
    bus(1'b1, `SADS_IDX_CTRL, 8'h71);
    bus(1'b1, `SADS_IDX_RES_LO, ~e[7:0]);
    conv(1'b1);
    chk(sar_code, {~rnd[9], rnd[8:0]});
    $display("test dac conversion done");
    bus(1'b1, `SADS_IDX_CTRL, 8'h11);
    bus(1'b1, `SADS_IDX_INPUT, 8'h22);
    bus(1'b1, `SADS_IDX_INPUT, 8'ha2);
    cmp_out <= 1'b1;
    timer_ovf <= 3'b001;
    @(posedge hclk);
    timer_ovf <= 3'b100;
    @(posedge hclk);
    timer_ovf <= 3'b010;
    chk(start_busy, 1'b0);
    @(posedge hclk);
    timer_ovf <= 3'b000;
    chk(start_busy, 1'b0);
    conv(1'b0);
    bus(1'b0, `SADS_IDX_RES_LO, 8'hff);
    bus(1'b0, `SADS_IDX_RES_HI, 8'h01);
    bus(1'b1, `SADS_IDX_CTRL, 8'h00);
    bus(1'b0, `SADS_IDX_CTRL, 8'h00);
    chk(ana_power | rc_osc_enable, 1'b0);
    $display("test timer trigger done");
    report_and_stop();
  end
endmodule
